// File: core/interrupt_latch_arbiter.sv
// Design decisions made here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module interrupt_latch_arbiter (
  input wire logic mclk,
  input wire logic arst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Peripheral flags and their enables
  input wire logic [irq_latch_pkg::NFLAG-1:0] flagIn,
  input wire logic [irq_latch_pkg::NFLAG-1:0] enIn,
  // Core side
  input wire logic instrDone,
  input wire logic swiExec,
  input wire logic rtiExec,
  input wire logic iMask,
  input wire logic entryAck,
  output logic entryReq,
  output logic [4:0] vectorCode,
  output logic [15:0] vectorAddr,
  output logic stackPcMinus1,
  output logic stackIndexHigh,
  output logic pushRegs,
  output logic setIMask,
  output logic restoreRegs,
  output logic prefetchOp,
  output logic irqOut
);
  import irq_latch_pkg::*;

  // ****************************************
  // Request gathering
  // ****************************************
  logic [NSRC:1] pend;
  logic [4:0] cand;
  logic anyPend;
  logic boundary;
  state_type s;
  state_type n;

  genvar gs;
  generate
    for (gs = 1; gs <= NSRC; gs++) begin : g_src
      logic [NFLAG-1:0] hit;
      genvar gf;
      for (gf = 0; gf < NFLAG; gf++) begin : g_flag
        assign hit[gf] = flagIn[gf] & enIn[gf] &
          (FLAG_SRC[gf] == 5'(gs));
      end
      assign pend[gs] = |hit;
    end
  endgenerate

  always_comb begin
    cand = 5'h00;
    for (int i = NSRC; i >= 1; i--) begin
      if (pend[i]) begin
        cand = 5'(i);
      end
    end
  end

  assign anyPend = |pend;
  assign boundary = instrDone | rtiExec;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    n = s;
    n.pushRegs = 1'b0;
    n.setIMask = 1'b0;
    n.restoreRegs = 1'b0;
    n.prefetchOp = 1'b0;
    n.restoreRegs = rtiExec;
    n.prefetchOp = rtiExec;
    unique case (s.fsm)
      ST_IDLE: begin
        if (swiExec) begin
          n.fsm = ST_LATCH;
          n.code = CODE_SWI;
          n.software_interrupt = 1'b1;
          n.entryReq = 1'b1;
          n.stackPcMinus1 = 1'b0;
          n.vecAddr = VEC_TOP;
        end else if (boundary && !iMask && anyPend) begin
          n.fsm = ST_LATCH;
          n.code = cand;
          n.software_interrupt = 1'b0;
          n.entryReq = 1'b1;
          n.stackPcMinus1 = 1'b1;
          n.vecAddr = VEC_TOP - {10'h000, cand, 1'b0};
        end
      end
      ST_LATCH: begin
        if (entryAck) begin
          n.fsm = ST_IDLE;
          n.entryReq = 1'b0;
          n.pushRegs = 1'b1;
          n.setIMask = 1'b1;
        end else if (!iMask && !s.software_interrupt && !pend[s.code]) begin
          n.fsm = ST_IDLE;
          n.entryReq = 1'b0;
        end
      end
    endcase
    // Sticky events, set wins over read clear
    if (s.ack && !wb_we_i && wb_adr_i == ADDR_EVENT) begin
      n.events = '0;
    end
    if (s.fsm == ST_LATCH && entryAck) begin
      n.events[EV_ENTRY] = 1'b1;
    end
    if (s.fsm == ST_IDLE && swiExec) begin
      n.events[EV_SWI] = 1'b1;
    end
    if (rtiExec) begin
      n.events[EV_RETURN] = 1'b1;
    end
    // Wishbone: ack one cycle after strobe
    n.ack = wb_cyc_i & wb_stb_i & ~s.ack;
    n.rdata = 32'h0000_0000;
    // Mask write lands on the edge that sees ack high
    if (s.ack && wb_cyc_i && wb_stb_i && wb_we_i &&
      wb_adr_i == ADDR_MASK && wb_sel_i[0]) begin
      n.evMask = wb_dat_i[EVW-1:0];
    end
    // Read data captured on the taken edge
    if (wb_cyc_i && wb_stb_i && !s.ack) begin
      unique case (wb_adr_i)
        ADDR_FLAGS: n.rdata = {8'h00, pend};
        ADDR_EVENT: n.rdata = {29'h0, s.events};
        ADDR_MASK: n.rdata = {29'h0, s.evMask};
        ADDR_STATE: n.rdata = {24'h0, s.software_interrupt, s.entryReq,
          s.code == 5'h00 ? 1'b0 : 1'b1, s.code};
        default: n.rdata = 32'h0000_0000;
      endcase
    end
    n.irq = |(n.events & n.evMask);
  end

  // ****************************************
  // State register
  // ****************************************
  // reset bypasses arbitration
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.fsm <= ST_IDLE;
      s.vecAddr <= VEC_RESET;
      s.evMask <= MASK_RST;
    end else begin
      s <= n;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Register bus answer
  assign wb_dat_o = s.rdata;
  assign wb_ack_o = s.ack;

  // Latched entry and its vector
  assign entryReq = s.entryReq;
  assign vectorCode = s.code;
  assign vectorAddr = s.vecAddr;
  assign stackPcMinus1 = s.stackPcMinus1;

  assign stackIndexHigh = 1'b0;

  // Entry stacking pulses
  assign pushRegs = s.pushRegs;
  assign setIMask = s.setIMask;

  // Return pulses
  assign restoreRegs = s.restoreRegs;
  assign prefetchOp = s.prefetchOp;

  // Event interrupt level
  assign irqOut = s.irq;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_swi_taken: assert property (
    s.fsm == ST_IDLE && swiExec |=> entryReq && vectorCode == 5'h00)
    else $error("software interrupt not taken");

  a_mask_gates: assert property (
    s.fsm == ST_IDLE && !swiExec && iMask |=> !entryReq)
    else $error("masked request entered");

  a_code_held: assert property (
    s.fsm == ST_LATCH && !entryAck && iMask |=> $stable(vectorCode))
    else $error("latched code displaced");

  a_lowest_wins: assert property (
    s.fsm == ST_IDLE && !swiExec && boundary && !iMask && pend[1]
    |=> vectorCode == 5'h01)
    else $error("priority order broken");

  a_no_mid_instr: assert property (
    s.fsm == ST_IDLE && !swiExec && !boundary |=> !entryReq)
    else $error("entry without boundary");

  a_entry_pulse: assert property (
    s.fsm == ST_LATCH && entryAck |=> pushRegs && setIMask ##1 !pushRegs)
    else $error("entry stacking pulse wrong");

  a_return_acts: assert property (
    rtiExec |=> restoreRegs && prefetchOp)
    else $error("return did not restore or prefetch");

  a_pc_choice: assert property (
    entryReq |-> stackPcMinus1 == (vectorCode != 5'h00))
    else $error("stacked counter choice wrong");

  a_vec_table: assert property (
    entryReq |-> vectorAddr == VEC_TOP - {10'h000, vectorCode, 1'b0})
    else $error("vector address mismatch");

  a_hidx_kept: assert property (
    pushRegs |-> !stackIndexHigh)
    else $error("high index stacked");

  // Bus ack is a single pulse
  a_ack_once: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  a_restore_only: assert property (
    !rtiExec |=> !restoreRegs)
    else $error("restore without return");

  a_prefetch_only: assert property (
    !rtiExec |=> !prefetchOp)
    else $error("prefetch without return");

  a_latch_code: assert property (
    s.fsm == ST_IDLE && !swiExec && boundary && !iMask && anyPend
    |=> entryReq && vectorCode == $past(cand))
    else $error("arbitration result not latched");

  a_latch_nonzero: assert property (
    entryReq && !s.software_interrupt |-> vectorCode != 5'h00)
    else $error("hardware entry with zero code");

  a_no_pend_idle: assert property (
    s.fsm == ST_IDLE && !swiExec && !anyPend |=> !entryReq)
    else $error("entry with nothing pending");

  a_swi_no_pc1: assert property (
    s.software_interrupt && entryReq |-> !stackPcMinus1)
    else $error("software entry stacks counter minus one");

  a_rst_vec: assert property (
    entryReq |-> vectorAddr != VEC_RESET)
    else $error("reset vector from arbitration");

  a_return_chain: assert property (
    s.fsm == ST_IDLE && rtiExec && !swiExec && !iMask && anyPend
    |=> entryReq)
    else $error("pending request skipped at return");

  a_flags_live: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o && wb_adr_i == ADDR_FLAGS
    |=> wb_dat_o == {8'h00, $past(pend)})
    else $error("status flags read wrong");

  a_first_flag: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o && wb_adr_i == ADDR_FLAGS
    |=> wb_dat_o[0] == $past(pend[1]))
    else $error("first source flag misplaced");

  a_last_flag: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o && wb_adr_i == ADDR_FLAGS
    |=> wb_dat_o[23] == $past(pend[NSRC]))
    else $error("last source flag misplaced");

  a_shared_nine: assert property (
    pend[9] == |(flagIn[10:8] & enIn[10:8]))
    else $error("shared request nine wrong");

  a_shared_eleven: assert property (
    pend[11] == |(flagIn[15:12] & enIn[15:12]))
    else $error("shared request eleven wrong");

  // Bus answers one cycle after taken
  a_ack_answer: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");

  // Bus quiet without request
  a_no_ack_idle: assert property (
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");

  // Mask write lands at ack
  a_mask_write: assert property (
    wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i &&
    wb_adr_i == ADDR_MASK && wb_sel_i[0]
    |=> s.evMask == $past(wb_dat_i[EVW-1:0]))
    else $error("mask write lost");

  // Entry event set wins
  a_entry_event: assert property (
    s.fsm == ST_LATCH && entryAck |=> s.events[EV_ENTRY])
    else $error("entry event lost");

  // Software event set wins
  a_swi_event: assert property (
    s.fsm == ST_IDLE && swiExec |=> s.events[EV_SWI])
    else $error("software event lost");

  // Return event set wins
  a_ret_event: assert property (
    rtiExec |=> s.events[EV_RETURN])
    else $error("return event lost");

  a_push_only: assert property (
    !(s.fsm == ST_LATCH && entryAck) |=> !pushRegs && !setIMask)
    else $error("stacking without entry");

  a_latch_stays: assert property (
    s.fsm == ST_LATCH && !entryAck && iMask |=> entryReq)
    else $error("latched entry dropped while masked");

  c_mask_write: cover property (wb_ack_o && wb_we_i);
  c_hw_entry: cover property (
    entryReq && !s.software_interrupt ##[1:8] pushRegs);
  c_swi_entry: cover property (swiExec ##1 entryReq && s.software_interrupt);
  c_return_chain: cover property (rtiExec ##1 entryReq);
  c_irq_out: cover property (irqOut);

endmodule
`default_nettype wire

// File: core/irq_latch_pkg.sv
package irq_latch_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NSRC = 24;
  localparam int NFLAG = 38;
  localparam int EVW = 3;

  // ****************************************
  // Vector table
  // ****************************************
  localparam logic [4:0] CODE_SWI = 5'h00;
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_TOP = 16'hFFFC;
  // Source of each peripheral flag, flag 37 first
  localparam logic [NFLAG-1:0][4:0] FLAG_SRC = {
    5'h18, 5'h17, 5'h16, 5'h15, 5'h14, 5'h14, 5'h14, 5'h13,
    5'h12, 5'h12, 5'h12, 5'h12, 5'h12, 5'h12, 5'h11, 5'h10,
    5'h0F, 5'h0E, 5'h0D, 5'h0D, 5'h0C, 5'h0C, 5'h0B, 5'h0B,
    5'h0B, 5'h0B, 5'h0A, 5'h09, 5'h09, 5'h09, 5'h08, 5'h07,
    5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01};

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_FLAGS = 8'h00;
  localparam logic [7:0] ADDR_EVENT = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_STATE = 8'h0C;
  localparam int EV_ENTRY = 0;
  localparam int EV_SWI = 1;
  localparam int EV_RETURN = 2;
  localparam logic [EVW-1:0] MASK_RST = 3'h0;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_LATCH = 1'b1
  } fsm_type;

  typedef struct packed {
    fsm_type fsm;
    logic [4:0] code;
    logic software_interrupt;
    logic [15:0] vecAddr;
    logic entryReq;
    logic stackPcMinus1;
    logic pushRegs;
    logic setIMask;
    logic restoreRegs;
    logic prefetchOp;
    logic [EVW-1:0] events;
    logic [EVW-1:0] evMask;
    logic irq;
    logic ack;
    logic [31:0] rdata;
  } state_type;

endpackage

// File: verif/core_model.sv
`timescale 1ns/100ps
`default_nettype none
// Core model: fetches the vector of a latched entry after a set delay
module core_model (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic entryReq,
  input wire logic ackEn,
  input wire logic [3:0] ackDelay,
  output logic entryAck
);
  logic [3:0] waitCnt_reg;
  // One fetch per latched entry, prompt or slow
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      entryAck <= 1'h0;
      waitCnt_reg <= 4'h0;
    end else if (entryAck || !entryReq) begin
      entryAck <= 1'h0;
      waitCnt_reg <= 4'h0;
    end else if (ackEn) begin
      entryAck <= (waitCnt_reg == ackDelay);
      waitCnt_reg <= waitCnt_reg + 4'h1;
    end
  end
endmodule
`default_nettype wire

// File: verif/tb_interrupt_latch_arbiter.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checksDone++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb_interrupt_latch_arbiter;
  import irq_latch_pkg::*;
  logic mclk = 1'h0, arst_n = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdo, q;
  logic [NFLAG-1:0] flags = '0, ens = '1;
  logic instrDone = 1'h0, swiExec = 1'h0, rtiExec = 1'h0, iMask = 1'h0;
  logic ackEn = 1'h0, entryAck, entryReq, pcm1, idxHigh, ack, irqOut;
  logic pushRegs, setIMask, restoreRegs, prefetchOp;
  logic [3:0] ackDly = 4'h0;
  logic [4:0] code;
  logic [15:0] vaddr;
  int failures = 0, checksDone = 0, nPush = 0, nRest = 0, nPre = 0;
  // ****
  // Design, core and clock
  // ****
  interrupt_latch_arbiter u_interrupt_latch_arbiter (.mclk(mclk),
    .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdo),
    .wb_ack_o(ack), .flagIn(flags), .enIn(ens), .instrDone(instrDone),
    .swiExec(swiExec), .rtiExec(rtiExec), .iMask(iMask),
    .entryAck(entryAck), .entryReq(entryReq), .vectorCode(code),
    .vectorAddr(vaddr), .stackPcMinus1(pcm1), .stackIndexHigh(idxHigh),
    .pushRegs(pushRegs), .setIMask(setIMask), .restoreRegs(restoreRegs),
    .prefetchOp(prefetchOp), .irqOut(irqOut));
  core_model u_core_model (.mclk(mclk), .arst_n(arst_n),
    .entryReq(entryReq), .ackEn(ackEn), .ackDelay(ackDly),
    .entryAck(entryAck));
  initial forever #10 mclk = ~mclk;
  // Count core-side pulses
  always @(posedge mclk) begin
    nPush += (pushRegs && setIMask);
    nRest += restoreRegs;
    nPre += prefetchOp;
  end
  // ****
  // Shared tasks
  // ****
  task automatic stop_test();
    $display("checks %0d failures %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'h1 && n < 20);
    q = rdo;
    cyc <= 1'h0;
    stb <= 1'h0;
    if (n >= 20) begin
      failures++;
      stop_test();
    end
  endtask
  task automatic step(input logic [2:0] p);
    @(posedge mclk);
    {instrDone, swiExec, rtiExec} <= p;
    @(posedge mclk);
    {instrDone, swiExec, rtiExec} <= 3'h0;
    #1;
  endtask
  task automatic drain();
    int n, p0;
    n = 0;
    p0 = nPush;
    @(posedge mclk);
    ackEn <= 1'h1;
    while (entryReq === 1'h1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    ackEn <= 1'h0;
    @(posedge mclk);
    #1;
    `CHK("push", 1, nPush - p0)
    if (n >= 20) begin
      failures++;
      stop_test();
    end
  endtask
  task automatic irqIs(input logic e);
    repeat (2) @(posedge mclk);
    #1;
    `CHK("irq", e, irqOut)
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_prio();
    @(posedge mclk);
    flags[2] <= 1'h1;
    flags[4] <= 1'h1;
    step(3'h4);
    `CHK("req", 1'h1, entryReq)
    `CHK("code", 5'h03, code)
    `CHK("vec", 16'hFFF6, vaddr)
    `CHK("pcm1", 1'h1, pcm1)
    `CHK("idxh", 1'h0, idxHigh)
    flags[0] <= 1'h1;
    step(3'h4);
    `CHK("held", 5'h03, code)
    drain();
    flags <= '0;
    $display("done prio");
  endtask
  task automatic t_mask();
    @(posedge mclk);
    iMask <= 1'h1;
    flags[1] <= 1'h1;
    repeat (3) @(posedge mclk);
    #1;
    `CHK("noabort", 1'h0, entryReq)
    step(3'h4);
    `CHK("masked", 1'h0, entryReq)
    iMask <= 1'h0;
    ens[1] <= 1'h0;
    step(3'h4);
    `CHK("disabled", 1'h0, entryReq)
    iMask <= 1'h1;
    ens[1] <= 1'h1;
    step(3'h2);
    `CHK("swi", 1'h1, entryReq)
    `CHK("swicode", 5'h00, code)
    `CHK("swivec", 16'hFFFC, vaddr)
    `CHK("swipc", 1'h0, pcm1)
    ackDly <= 4'h3;
    drain();
    flags <= '0;
    iMask <= 1'h0;
    $display("done mask");
  endtask
  task automatic t_rti();
    int r0, f0;
    r0 = nRest;
    f0 = nPre;
    @(posedge mclk);
    flags[1] <= 1'h1;
    step(3'h1);
    `CHK("retcode", 5'h02, code)
    `CHK("retvec", 16'hFFF8, vaddr)
    @(posedge mclk);
    #1;
    `CHK("restore", 1, nRest - r0)
    `CHK("prefetch", 1, nPre - f0)
    drain();
    flags <= '0;
    $display("done rti");
  endtask
  task automatic t_regs();
    @(posedge mclk);
    flags[9] <= 1'h1;
    flags[11] <= 1'h1;
    ens[11] <= 1'h0;
    wb(1'h0, 8'h00, 32'h0);
    `CHK("shared", 32'h100, q)
    wb(1'h1, 8'h00, 32'hFFFFFFFF);
    wb(1'h0, 8'h00, 32'h0);
    `CHK("ro", 32'h100, q)
    wb(1'h0, 8'h10, 32'h0);
    `CHK("unmapped", 32'h0, q)
    wb(1'h0, 8'h04, 32'h0);
    wb(1'h1, 8'h08, 32'h1);
    step(3'h4);
    drain();
    irqIs(1'h1);
    wb(1'h1, 8'h08, 32'h0);
    irqIs(1'h0);
    wb(1'h1, 8'h08, 32'h1);
    irqIs(1'h1);
    wb(1'h0, 8'h04, 32'h0);
    `CHK("event", 32'h1, q)
    irqIs(1'h0);
    flags <= '0;
    ens <= '1;
    $display("done regs");
  endtask
  // ****
  // Main sequence and watchdog
  // ****
  initial begin
    repeat (3) @(posedge mclk);
    arst_n <= 1'h1;
    @(posedge mclk);
    #1;
    `CHK("rstvec", 16'hFFFE, vaddr)
    `CHK("rstreq", 1'h0, entryReq)
    t_prio();
    t_mask();
    t_rti();
    t_regs();
    stop_test();
  end
  initial begin
    #200000;
    failures++;
    stop_test();
  end
endmodule
`default_nettype wire
